// file: hw/fsg_slave_top.sv
// Functional notes
// RULE_01: Accept frame only with fieldbus EtherType.
// RULE_02: Process only header type one.
// RULE_03: NOP performs no memory access.
// RULE_04: Position commands increment; act at zero.
// RULE_05: Node commands act on station match.
// RULE_06: Broadcast commands always act.
// RULE_07: Logical commands act inside mapped area.
// RULE_08: ARMW increments; read at zero, else write.
// RULE_09: FRMW reads on match, writes otherwise.
// RULE_10: Reserved codes: no access, unchanged.
// RULE_11: Init blocks mailbox and process data.
// RULE_12: PreOP allows mailbox only.
// RULE_13: SafeOP adds slave-to-master process data.
// RULE_14: OP allows all traffic.
// RULE_15: Register access allowed in every state.
// RULE_16: Master keeps sync running through OP exit.
// RULE_17: Master waits for each transition completion.
// RULE_18: Test functions: Init only unless bit set.
// RULE_19: Not-ready power stage only in Init.
// RULE_20: Going to Init forces switch-on-disabled.
// RULE_21: Change during operation-enabled raises error, Fault.
// RULE_22: Stay OP until deceleration ends, then transition.
// RULE_23: Non-network fault keeps application state.
// RULE_24: Master enables operation only in OP.
// RULE_25: Master timeout covers slow transitions.
`timescale 1ns/100ps
`default_nettype none
`include "fsg_params.svh"
module fsg_slave_top
  import fsg_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              dgValid,
  input  wire logic [15:0]       etherType,
  input  wire logic [3:0]        fbHdrType,
  input  wire logic [7:0]        dgCmd,
  input  wire logic [ADDR_W-1:0] dgAddr,
  input  wire logic [15:0]       stationAddr,
  input  wire logic              logicalHit,
  input  wire logic              regSpace,
  input  wire logic              alReqValid,
  input  wire logic [3:0]        alReqState,
  input  wire logic              localFault,
  input  wire logic              decelDone,
  input  wire logic [1:0]        pdsCmd,
  input  wire logic              pdsCmdValid,
  input  wire logic              testCfg,
  output logic                   memRead,
  output logic                   memWrite,
  output logic                   memRegOnly,
  output logic [ADDR_W-1:0]      dgAddrOut,
  output logic                   dgOutValid,
  output logic [3:0]             alStateOut,
  output logic                   alBusy,
  output logic [6:0]             pdsStateOut,
  output logic                   errValid,
  output logic [7:0]             errMain,
  output logic [3:0]             errSub,
  output logic                   mbxEn,
  output logic                   pdoTxEn,
  output logic                   pdoRxEn,
  output logic                   testAllowed
);
  initial begin
    if (ADDR_W < 16) $error("ADDR_W below 16");
  end

  fsg_gate_if gate();

  fsg_al_t  alState_reg;
  fsg_al_t  alTarget_reg;
  logic     alPend_reg;
  fsg_pds_t pdsState_reg;
  logic     errValid_reg;
  logic     frameOk;
  fsg_acc_t acc;
  logic     incAddr;
  logic     reqLegal;
  fsg_al_t  reqState;

  assign gate.alState = alState_reg;

  fsg_traffic_gate u_gate (
    .gate (gate)
  );

  assign mbxEn   = gate.mbxEn;
  assign pdoTxEn = gate.pdoTxEn;
  assign pdoRxEn = gate.pdoRxEn;

  fsg_cmd_decode #(
    .ADDR_W (ADDR_W)
  ) u_dec (
    .cmd         (dgCmd),
    .adp         (dgAddr),
    .stationAddr (stationAddr),
    .logicalHit  (logicalHit),
    .acc         (acc),
    .incAddr     (incAddr)
  );

  assign frameOk = (etherType == `FSG_ETHERTYPE) // RULE_01
                && (fbHdrType == `FSG_HDR_TYPE_FB); // RULE_02

  // Datagram stage: access strobes and forwarded address
  always_ff @(posedge clk) begin
    if (rst) begin
      memRead    <= 1'b0;
      memWrite   <= 1'b0;
      memRegOnly <= 1'b0;
      dgAddrOut  <= '0;
      dgOutValid <= 1'b0;
    end else begin
      dgOutValid <= dgValid && frameOk; // RULE_01 RULE_02
      memRead    <= 1'b0;
      memWrite   <= 1'b0;
      memRegOnly <= 1'b0;
      if (dgValid && frameOk) begin
        dgAddrOut <= incAddr ? dgAddr + ADDR_W'(1) : dgAddr; // RULE_04 RULE_08
        // Register space ignores the traffic gate
        memRegOnly <= regSpace; // RULE_15
        memRead    <= acc[0]; // RULE_03 RULE_10
        memWrite   <= acc[1]; // RULE_03 RULE_10
      end
    end
  end

  always_comb begin
    reqLegal = 1'b1;
    reqState = FSG_AL_INIT;
    unique case (alReqState)
      4'h1: reqState = FSG_AL_INIT;
      4'h2: reqState = FSG_AL_PREOP;
      4'h4: reqState = FSG_AL_SAFEOP;
      4'h8: reqState = FSG_AL_OP;
      default: reqLegal = 1'b0;
    endcase
  end

  // Application-layer state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      alState_reg  <= FSG_AL_INIT;
      alTarget_reg <= FSG_AL_INIT;
      alPend_reg   <= 1'b0;
    end else if (alPend_reg) begin
      if (decelDone) begin
        alState_reg <= alTarget_reg; // RULE_22
        alPend_reg  <= 1'b0;
      end
    end else if (alReqValid && reqLegal && reqState != alState_reg) begin
      if (pdsState_reg == FSG_PDS_OPEN) begin
        alTarget_reg <= reqState; // RULE_22
        alPend_reg   <= 1'b1;
      end else begin
        alState_reg <= reqState;
      end
    end
  end

  assign alStateOut = alState_reg;
  assign alBusy     = alPend_reg;

  // Power-stage state
  always_ff @(posedge clk) begin
    if (rst) begin
      pdsState_reg <= FSG_PDS_NRDY;
    end else if (alReqValid && reqLegal && !alPend_reg
                 && reqState != alState_reg
                 && pdsState_reg == FSG_PDS_OPEN) begin
      pdsState_reg <= FSG_PDS_FRA; // RULE_21
    end else if (pdsState_reg == FSG_PDS_FRA && decelDone) begin
      pdsState_reg <= FSG_PDS_FAULT; // RULE_21 RULE_22
    end else if (localFault && pdsState_reg != FSG_PDS_FAULT
                 && pdsState_reg != FSG_PDS_NRDY) begin
      pdsState_reg <= FSG_PDS_FRA; // RULE_23
    end else if (alReqValid && reqLegal && !alPend_reg
                 && reqState == FSG_AL_INIT
                 && alState_reg != FSG_AL_INIT) begin
      pdsState_reg <= FSG_PDS_SOD; // RULE_20
    end else if (pdsState_reg == FSG_PDS_NRDY
                 && (alState_reg != FSG_AL_INIT
                     || (alReqValid && reqLegal && !alPend_reg
                         && reqState != FSG_AL_INIT))) begin
      // Leave not-ready on the same edge that leaves Init
      pdsState_reg <= FSG_PDS_SOD; // RULE_19
    end else if (pdsCmdValid) begin
      unique case (pdsState_reg)
        FSG_PDS_SOD:
          if (pdsCmd == 2'h1 && alState_reg != FSG_AL_INIT)
            pdsState_reg <= FSG_PDS_RDY; // RULE_19
        FSG_PDS_RDY: begin
          if (pdsCmd == 2'h2) pdsState_reg <= FSG_PDS_SWON;
          if (pdsCmd == 2'h0) pdsState_reg <= FSG_PDS_SOD;
        end
        FSG_PDS_SWON: begin
          if (pdsCmd == 2'h3) pdsState_reg <= FSG_PDS_OPEN;
          if (pdsCmd == 2'h0) pdsState_reg <= FSG_PDS_SOD;
        end
        FSG_PDS_OPEN:
          if (pdsCmd == 2'h0) pdsState_reg <= FSG_PDS_SOD;
        FSG_PDS_FAULT:
          if (pdsCmd == 2'h0) pdsState_reg <= FSG_PDS_SOD;
        FSG_PDS_NRDY, FSG_PDS_FRA: pdsState_reg <= pdsState_reg;
        default: pdsState_reg <= FSG_PDS_FAULT;
      endcase
    end
  end

  assign pdsStateOut = pdsState_reg;

  // Error report for state change while operating
  always_ff @(posedge clk) begin
    if (rst) begin
      errValid_reg <= 1'b0;
    end else if (alReqValid && reqLegal && !alPend_reg
                 && reqState != alState_reg
                 && pdsState_reg == FSG_PDS_OPEN) begin
      errValid_reg <= 1'b1; // RULE_21
    end else if (pdsState_reg == FSG_PDS_SOD) begin
      errValid_reg <= 1'b0;
    end
  end

  assign errValid = errValid_reg;
  assign errMain  = `FSG_ERR_ESM_OPEN;
  assign errSub   = `FSG_ERR_ESM_SUB;

  assign testAllowed = testCfg || (alState_reg == FSG_AL_INIT); // RULE_18

endmodule : fsg_slave_top
`default_nettype wire

// file: hw/fsg_params.svh
`ifndef FSG_PARAMS_SVH
`define FSG_PARAMS_SVH

`define FSG_ETHERTYPE      16'h88a4
`define FSG_HDR_TYPE_FB    4'h1
`define FSG_CMD_NOP        8'h00
`define FSG_CMD_APRD       8'h01
`define FSG_CMD_APWR       8'h02
`define FSG_CMD_APRW       8'h03
`define FSG_CMD_FPRD       8'h04
`define FSG_CMD_FPWR       8'h05
`define FSG_CMD_FPRW       8'h06
`define FSG_CMD_BRD        8'h07
`define FSG_CMD_BWR        8'h08
`define FSG_CMD_BRW        8'h09
`define FSG_CMD_LRD        8'h0a
`define FSG_CMD_LWR        8'h0b
`define FSG_CMD_LRW        8'h0c
`define FSG_CMD_ARMW       8'h0d
`define FSG_CMD_FRMW       8'h0e
`define FSG_CMD_LAST       8'h0e
`define FSG_TESTCFG_BIT    0
`define FSG_ERR_ESM_OPEN   8'h58
`define FSG_ERR_ESM_SUB    4'h2

`endif

// file: hw/fsg_pkg.sv
package fsg_pkg;
  typedef enum logic [3:0] {
    FSG_AL_INIT   = 4'b0001,
    FSG_AL_PREOP  = 4'b0010,
    FSG_AL_SAFEOP = 4'b0100,
    FSG_AL_OP     = 4'b1000
  } fsg_al_t;

  typedef enum logic [6:0] {
    FSG_PDS_NRDY  = 7'b0000001,
    FSG_PDS_SOD   = 7'b0000010,
    FSG_PDS_RDY   = 7'b0000100,
    FSG_PDS_SWON  = 7'b0001000,
    FSG_PDS_OPEN  = 7'b0010000,
    FSG_PDS_FRA   = 7'b0100000,
    FSG_PDS_FAULT = 7'b1000000
  } fsg_pds_t;

  typedef enum logic [1:0] {
    FSG_ACC_NONE  = 2'h0,
    FSG_ACC_READ  = 2'h1,
    FSG_ACC_WRITE = 2'h2,
    FSG_ACC_RW    = 2'h3
  } fsg_acc_t;
endpackage : fsg_pkg

// file: hw/fsg_gate_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fsg_gate_if;
  import fsg_pkg::*;
  fsg_al_t alState;
  logic    mbxEn;
  logic    pdoTxEn;
  logic    pdoRxEn;
  modport src (output alState);
  modport dst (input alState, output mbxEn, output pdoTxEn, output pdoRxEn);
endinterface : fsg_gate_if
`default_nettype wire

// file: hw/fsg_cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsg_params.svh"
module fsg_cmd_decode
  import fsg_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic [7:0]        cmd,
  input  wire logic [ADDR_W-1:0] adp,
  input  wire logic [15:0]       stationAddr,
  input  wire logic              logicalHit,
  output var fsg_acc_t           acc,
  output logic                   incAddr
);
  initial begin
    if (ADDR_W < 16) $error("ADDR_W below 16");
  end

  logic posZero;
  logic nodeHit;
  assign posZero = (adp == '0);
  assign nodeHit = (adp[15:0] == stationAddr);

  always_comb begin
    acc     = FSG_ACC_NONE;
    incAddr = 1'b0;
    case (cmd)
      `FSG_CMD_NOP: acc = FSG_ACC_NONE; // RULE_03
      `FSG_CMD_APRD, `FSG_CMD_APWR, `FSG_CMD_APRW: begin
        incAddr = 1'b1; // RULE_04
        if (posZero) acc = fsg_acc_t'(cmd[1:0]); // RULE_04
      end
      `FSG_CMD_FPRD: if (nodeHit) acc = FSG_ACC_READ; // RULE_05
      `FSG_CMD_FPWR: if (nodeHit) acc = FSG_ACC_WRITE; // RULE_05
      `FSG_CMD_FPRW: if (nodeHit) acc = FSG_ACC_RW; // RULE_05
      `FSG_CMD_BRD:  acc = FSG_ACC_READ; // RULE_06
      `FSG_CMD_BWR:  acc = FSG_ACC_WRITE; // RULE_06
      `FSG_CMD_BRW:  acc = FSG_ACC_RW; // RULE_06
      `FSG_CMD_LRD:  if (logicalHit) acc = FSG_ACC_READ; // RULE_07
      `FSG_CMD_LWR:  if (logicalHit) acc = FSG_ACC_WRITE; // RULE_07
      `FSG_CMD_LRW:  if (logicalHit) acc = FSG_ACC_RW; // RULE_07
      `FSG_CMD_ARMW: begin
        incAddr = 1'b1; // RULE_08
        acc = posZero ? FSG_ACC_READ : FSG_ACC_WRITE; // RULE_08
      end
      `FSG_CMD_FRMW:
        acc = nodeHit ? FSG_ACC_READ : FSG_ACC_WRITE; // RULE_09
      default: acc = FSG_ACC_NONE; // RULE_10
    endcase
  end
endmodule : fsg_cmd_decode
`default_nettype wire

// file: hw/fsg_traffic_gate.sv
`timescale 1ns/100ps
`default_nettype none
module fsg_traffic_gate
  import fsg_pkg::*;
(
  fsg_gate_if.dst gate
);
  always_comb begin
    gate.mbxEn   = 1'b0;
    gate.pdoTxEn = 1'b0;
    gate.pdoRxEn = 1'b0;
    unique case (gate.alState)
      FSG_AL_INIT: begin
        gate.mbxEn = 1'b0; // RULE_11
      end
      FSG_AL_PREOP: begin
        gate.mbxEn = 1'b1; // RULE_12
      end
      FSG_AL_SAFEOP: begin
        gate.mbxEn   = 1'b1; // RULE_13
        gate.pdoTxEn = 1'b1; // RULE_13
      end
      FSG_AL_OP: begin
        gate.mbxEn   = 1'b1; // RULE_14
        gate.pdoTxEn = 1'b1; // RULE_14
        gate.pdoRxEn = 1'b1; // RULE_14
      end
      default: begin
        gate.mbxEn = 1'b0;
      end
    endcase
  end
endmodule : fsg_traffic_gate
`default_nettype wire

// file: sim/fsg_slave_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fsg_slave_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              dgValid,
  input wire logic [15:0]       etherType,
  input wire logic [3:0]        fbHdrType,
  input wire logic [7:0]        dgCmd,
  input wire logic [ADDR_W-1:0] dgAddr,
  input wire logic              alReqValid,
  input wire logic [3:0]        alReqState,
  input wire logic              memRead,
  input wire logic              memWrite,
  input wire logic [ADDR_W-1:0] dgAddrOut,
  input wire logic              dgOutValid,
  input wire logic [3:0]        alStateOut,
  input wire logic              alBusy,
  input wire logic [6:0]        pdsStateOut,
  input wire logic              errValid,
  input wire logic              mbxEn,
  input wire logic              pdoTxEn,
  input wire logic              pdoRxEn
);
  wire logic fbOk = dgValid && etherType == 16'h88a4 && fbHdrType == 4'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bad_ether: assert property (
    dgValid && etherType != 16'h88a4 |=> !dgOutValid && !memRead)
    else $error("frame with foreign type accepted");
  a_bad_header: assert property (
    dgValid && fbHdrType != 4'h1 |=> !dgOutValid && !memWrite)
    else $error("frame with wrong header type accepted");
  a_nop_idle: assert property (
    fbOk && dgCmd == 8'h00 |=> dgOutValid && !memRead && !memWrite)
    else $error("no-op caused an access");
  a_pos_incr: assert property (
    fbOk && dgCmd == 8'h01 && dgAddr == '0 |=> memRead && !memWrite
    && dgAddrOut == $past(dgAddr) + 1'b1)
    else $error("position read at zero wrong");
  a_bcast_write: assert property (
    fbOk && dgCmd == 8'h08 |=> memWrite && !memRead)
    else $error("broadcast write not performed");
  a_resv_idle: assert property (
    fbOk && dgCmd > 8'h0e |=> !memRead && !memWrite)
    else $error("reserved code caused an access");
  a_init_gate: assert property (
    alStateOut == 4'h1 |-> !(mbxEn || pdoTxEn || pdoRxEn))
    else $error("traffic open in init");
  a_safeop_gate: assert property (
    alStateOut == 4'h4 |-> mbxEn && pdoTxEn && !pdoRxEn)
    else $error("safe-op gating wrong");
  a_nrdy_init: assert property (
    pdsStateOut == 7'h01 |-> alStateOut == 4'h1)
    else $error("not-ready power stage outside init");
  a_open_err: assert property (
    alReqValid && $onehot(alReqState) && alReqState != alStateOut
    && pdsStateOut == 7'h10 && !alBusy
    |=> errValid && alBusy && pdsStateOut == 7'h20)
    else $error("change while enabled not faulted");
endmodule : fsg_slave_monitor
bind fsg_slave_top fsg_slave_monitor #(.ADDR_W(ADDR_W)) fsg_slave_monitor_inst (
  .clk, .rst, .dgValid, .etherType, .fbHdrType, .dgCmd, .dgAddr,
  .alReqValid, .alReqState, .memRead, .memWrite, .dgAddrOut, .dgOutValid,
  .alStateOut,
  .alBusy, .pdsStateOut, .errValid, .mbxEn, .pdoTxEn, .pdoRxEn
);
`default_nettype wire

// file: sim/fsg_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsg_master_model (
  input  wire logic       clk,
  input  wire logic [3:0] alStateOut,
  output var logic        dgValid,
  output var logic [15:0] etherType,
  output var logic [3:0]  fbHdrType,
  output var logic [7:0]  dgCmd,
  output var logic [15:0] dgAddr,
  output var logic        alReqValid,
  output var logic [3:0]  alReqState,
  output var logic [1:0]  pdsCmd,
  output var logic        pdsCmdValid
);
  initial begin
    {dgValid, alReqValid, pdsCmdValid, pdsCmd} = '0;
    {etherType, fbHdrType, dgCmd, dgAddr} = '0;
    alReqState = 4'h1;
  end
  task send(input logic [7:0] c, input logic [15:0] a, et,
            input logic [3:0] ht);
    @(posedge clk);
    dgValid <= 1'b1;
    {dgCmd, dgAddr, etherType, fbHdrType} <= {c, a, et, ht};
    @(posedge clk);
    dgValid <= 1'b0;
    {dgCmd, dgAddr} <= {~c, ~a};
  endtask : send
  task ask(input logic [3:0] s);
    @(posedge clk);
    alReqValid <= 1'b1;
    alReqState <= s;
    @(posedge clk);
    alReqValid <= 1'b0;
  endtask : ask
  // Generous bound: slow transitions wait on deceleration
  task await(input logic [3:0] s, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(posedge clk);
      #1 ok = (alStateOut === s);
    end
  endtask : await
  task power(input logic [1:0] c);
    if (c == 2'h3 && alStateOut !== 4'h8) return;
    @(posedge clk);
    pdsCmdValid <= 1'b1;
    pdsCmd <= c;
    @(posedge clk);
    pdsCmdValid <= 1'b0;
  endtask : power
endmodule : fsg_master_model
`default_nettype wire

// file: sim/fsg_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rst = 1'b1, logicalHit = 1'b0, regSpace = 1'b0;
  logic        localFault = 1'b0, decelDone = 1'b0, testCfg = 1'b0;
  logic [15:0] stationAddr = 16'h1234;
  logic        dgValid, alReqValid, pdsCmdValid, memRead, memWrite;
  logic        memRegOnly, dgOutValid, alBusy, errValid, mbxEn;
  logic        pdoTxEn, pdoRxEn, testAllowed;
  logic [15:0] etherType, dgAddr, dgAddrOut;
  logic [7:0]  dgCmd, errMain;
  logic [3:0]  fbHdrType, alReqState, alStateOut, errSub;
  logic [1:0]  pdsCmd;
  logic [6:0]  pdsStateOut;
  int          mismatches = 0, comparisons = 0;
  always #2 clk = ~clk;
  fsg_slave_top fsg_slave_top_inst (
    .clk, .rst, .dgValid, .etherType, .fbHdrType, .dgCmd, .dgAddr,
    .stationAddr, .logicalHit, .regSpace, .alReqValid, .alReqState,
    .localFault, .decelDone, .pdsCmd, .pdsCmdValid, .testCfg, .memRead,
    .memWrite, .memRegOnly, .dgAddrOut, .dgOutValid, .alStateOut, .alBusy,
    .pdsStateOut, .errValid, .errMain, .errSub, .mbxEn, .pdoTxEn,
    .pdoRxEn, .testAllowed
  );
  fsg_master_model fsg_master_model_inst (
    .clk, .alStateOut, .dgValid, .etherType, .fbHdrType, .dgCmd, .dgAddr,
    .alReqValid, .alReqState, .pdsCmd, .pdsCmdValid
  );
  task close_out;
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task dg(input logic [7:0] c, input logic [15:0] a, e, input logic [1:0] rw);
    fsg_master_model_inst.send(c, a, 16'h88a4, 4'h1);
    #1 chk({dgOutValid, memRead, memWrite, dgAddrOut}, {1'b1, rw, e});
  endtask : dg
  task go(input logic [3:0] s);
    bit ok;
    fsg_master_model_inst.ask(s);
    fsg_master_model_inst.await(s, ok);
    if (!ok) begin
      mismatches++;
      close_out;
    end
  endtask : go
  task s_hdr;
    fsg_master_model_inst.send(8'h07, 16'h0, 16'h0800, 4'h1);
    #1 chk({dgOutValid, memRead}, 2'h0);
    fsg_master_model_inst.send(8'h07, 16'h0, 16'h88a4, 4'h2);
    #1 chk({dgOutValid, memRead}, 2'h0);
    dg(8'h00, 16'h0, 16'h0, 2'h0);
    dg(8'h0f, 16'h5, 16'h5, 2'h0);
    dg(8'hff, 16'h0, 16'h0, 2'h0);
  endtask : s_hdr
  task s_addr;
    logic [15:0] a;
    logic        h;
    for (int i = 1; i <= 12; i++)
      for (int j = 0; j < 2; j++) begin
        h = j[0] || (i >= 7 && i <= 9);
        case ((i - 1) / 3)
          0: a = j ? 16'h0 : 16'h5;
          1: a = j ? stationAddr : ~stationAddr;
          default: a = 16'h3;
        endcase
        @(posedge clk) logicalHit <= j[0];
        dg(8'(i), a, (i <= 3) ? a + 16'h1 : a,
           h ? {i % 3 != 2, i % 3 != 1} : 2'h0);
      end
  endtask : s_addr
  task s_rmw;
    dg(8'h0d, 16'h0, 16'h1, 2'h2);
    dg(8'h0d, 16'h3, 16'h4, 2'h1);
    dg(8'h0e, stationAddr, stationAddr, 2'h2);
    dg(8'h0e, 16'h9, 16'h9, 2'h1);
  endtask : s_rmw
  task s_state;
    chk({pdsStateOut, mbxEn, pdoTxEn, pdoRxEn, testAllowed}, 11'h011);
    @(posedge clk) regSpace <= 1'b1;
    dg(8'h07, 16'h0, 16'h0, 2'h2);
    chk(memRegOnly, 1'b1);
    @(posedge clk) regSpace <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      go(4'h1 << k);
      chk({mbxEn, pdoTxEn, pdoRxEn, testAllowed, pdsStateOut},
          {1'b1, k > 1, k == 3, 1'b0, 7'h02});
    end
    @(posedge clk) testCfg <= 1'b1;
    #1 chk(testAllowed, 1'b1);
    @(posedge clk) localFault <= 1'b1;
    @(posedge clk) localFault <= 1'b0;
    #1 chk({alStateOut, pdsStateOut}, {4'h8, 7'h20});
    go(4'h1);
    chk({pdsStateOut, mbxEn, pdoTxEn, pdoRxEn}, 10'h010);
  endtask : s_state
  task s_fault;
    for (int k = 1; k < 4; k++) go(4'h1 << k);
    for (int c = 1; c < 4; c++) fsg_master_model_inst.power(2'(c));
    #1 chk(pdsStateOut, 7'h10);
    fsg_master_model_inst.ask(4'h2);
    #1 chk({errValid, alBusy, pdsStateOut}, {2'h3, 7'h20});
    chk({errMain, errSub}, 12'h582);
    for (int n = 0; n < 4; n++)
      dg(8'h07, 16'h0, 16'h0, 2'h2);
    chk({alStateOut, alBusy}, {4'h8, 1'b1});
    @(posedge clk) decelDone <= 1'b1;
    go(4'h2);
    chk({alBusy, pdsStateOut}, {1'b0, 7'h40});
  endtask : s_fault
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 s_hdr;
    s_addr;
    s_rmw;
    s_state;
    s_fault;
    close_out;
  end
endmodule : tb
`default_nettype wire
